// ---- rf_frame_nvm.sv ----
// Contract
// - Nonzero offset shortens first byte, clears after
// - Offset zero packs a whole first byte; the last byte may be partial
// - Report valid bits of last byte
// - Offset nonzero: skip first parity check
// - Offset seven suppresses first byte
// - Missing start pattern sets frame error
// - Bad or short check block sets error
// - Wrong parity bit sets parity error
// - Bit collision sets collision error
// - Transceive sends then receives into FIFO
// - Wait delay and clock phase configurable
// - Readable three bit link state codes
// - Code 100 passed entering and leaving receive
// - Two address bytes, then data programmed
// - Memory write runs until idle command
// - Programming cycle 1..16 bytes, 5.8 ms
// - 16 byte buffer, start at end or empty
// - Done flag low while busy, irq on rise
// - Memory write unstoppable while not done
// - Block zero writes flag access error
// - Addresses wrap modulo 200h
// - Receive end returns idle, sets flags
// - Any error sets summary status bit
`include "rf_nvm_defines.svh"

module rf_frame_nvm #(
  parameter logic [19:0] PROG_CYCLES = 20'(`PROG_CYCLES)
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Register bus
  input wire rf_nvm_pkg::apb_req_type apb_in,
  output rf_nvm_pkg::apb_rsp_type apb_out,
  // Shared FIFO
  input wire logic fifo_empty_in,
  input wire logic [7:0] fifo_rdata_in,
  output logic fifo_rd_out,
  output logic fifo_wr_out,
  output logic [7:0] fifo_wdata_out,
  // Transmitter
  output logic tx_start_out,
  input wire logic [1:0] tx_phase_in,
  input wire logic tx_done_in,
  output logic [7:0] tx_rx_clock_phase_out,
  // Receiver decoder
  input wire logic bit_tick_in,
  input wire rf_nvm_pkg::rx_dec_type rx_dec_in,
  output logic rx_enable_out,
  // Non-volatile memory
  output rf_nvm_pkg::nvm_req_type nvm_out
);
  import rf_nvm_pkg::*;

  state_type s_ff;
  state_type nxt_s;
  logic wr_acc;
  logic start_prog;
  logic [4:0] err_set;
  logic [4:0] err_clr;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [7:0] rbyte;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `OFS_CMD, `OFS_STATUS, `OFS_ERR, `OFS_FRAME, `OFS_CTRL,
      `OFS_RECEIVE_WAIT_DELAY, `OFS_PHASE, `OFS_COLLISION_POSITION, `OFS_IRQ: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] link_code(input state_type s,
                                           input logic [1:0] txp);
    case (s.st)
      send_payload: link_code = {1'b0, txp};
      rx_start_transition: link_code = `LINK_TRANSITION;
      rx_finish_transition: link_code = `LINK_TRANSITION;
      rx_wait_phase: link_code = `LINK_RX_WAIT;
      rx_armed: link_code = `LINK_RX_ARMED;
      receiving: link_code = `LINK_RECEIVING;
      default: link_code = `LINK_IDLE;
    endcase
  endfunction

  function automatic logic in_write(input cmd_state_type st);
    in_write = (st == nv_addr_lo) || (st == nv_addr_hi) ||
               (st == nv_data);
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    err_set = 5'h00;
    err_clr = 5'h00;
    irq_set = 2'h0;
    irq_clr = 2'h0;
    start_prog = 1'b0;
    rbyte = fifo_rdata_in;
    nxt_s.fifo_rd = 1'b0;
    nxt_s.fifo_wr = 1'b0;
    nxt_s.tx_start = 1'b0;
    nxt_s.prog_start = 1'b0;
    wr_acc = apb_in.psel && apb_in.penable && apb_in.pwrite;

    // Read data is captured in the setup cycle so prdata is a flop
    // so a read shows its setup-cycle value
    if (apb_in.psel && !apb_in.penable) begin
      case (apb_in.paddr)
        `OFS_CMD: nxt_s.prdata = {26'h0, s_ff.cmd};
        `OFS_STATUS: nxt_s.prdata = {25'h0,
          link_code(s_ff, tx_phase_in),
          |s_ff.errs, s_ff.done, 2'h0};
        `OFS_ERR: nxt_s.prdata = {27'h0, s_ff.errs};
        `OFS_FRAME: nxt_s.prdata = {25'h0, s_ff.offset, 1'b0,
          s_ff.lastbits};
        `OFS_CTRL: nxt_s.prdata = {30'h0, s_ff.ctrl};
        `OFS_RECEIVE_WAIT_DELAY: nxt_s.prdata = {24'h0, s_ff.receive_wait_delay};
        `OFS_PHASE: nxt_s.prdata = {24'h0, s_ff.phase};
        `OFS_COLLISION_POSITION: nxt_s.prdata = {24'h0, s_ff.collision_position};
        `OFS_IRQ: nxt_s.prdata = {30'h0, s_ff.irq};
        default: nxt_s.prdata = 32'h0000_0000;
      endcase
    end

    // Programming timer; buffer is frozen while a cycle runs
    if (s_ff.prog) begin
      if (s_ff.prog_cnt == 20'h00000) begin
        nxt_s.prog = 1'b0;
        nxt_s.mask = 16'h0000;
      end else begin
        nxt_s.prog_cnt = s_ff.prog_cnt - 20'h00001;
      end
    end

    // FIFO fetch for the memory write command
    // One read in flight keeps bytes in order
    if (in_write(s_ff.st)) begin
      nxt_s.fifo_rd = !s_ff.rd_pend && !s_ff.fifo_rd && !fifo_empty_in &&
                      !s_ff.prog && !s_ff.prog_start;
    end
    nxt_s.rd_pend = s_ff.fifo_rd;

    case (s_ff.st)
      cmd_idle: begin
      end
      send_payload: begin
        if (tx_done_in) begin
          nxt_s.st = rx_start_transition;
        end
      end

      rx_start_transition: begin
        // Code 100 for one cycle
        nxt_s.st = rx_wait_phase;
        nxt_s.wait_cnt = s_ff.receive_wait_delay;
      end
      rx_wait_phase: begin
        if (bit_tick_in) begin
          nxt_s.wait_cnt = s_ff.wait_cnt - 8'h01;
          // Zero still arms after one tick
          if (s_ff.wait_cnt <= 8'h01) begin
            nxt_s.st = rx_armed;
          end
        end
      end

      rx_armed: begin
        if (rx_dec_in.sof || rx_dec_in.bad_sof) begin
          nxt_s.st = receiving;
          nxt_s.bitcnt = s_ff.offset;
          nxt_s.sh = 8'h00;
          nxt_s.first_byte = 1'b1;
          nxt_s.first_par = 1'b1;
          nxt_s.par = 1'b0;
          nxt_s.dbits = 8'h00;
          nxt_s.coll_seen = 1'b0;
          // A frame without its start pattern still runs to its end
          nxt_s.drop = rx_dec_in.bad_sof;
          err_set[`ERR_FRAME_BIT] = rx_dec_in.bad_sof;
        end
      end

      receiving: begin
        if (rx_dec_in.frame_end) begin
          if (s_ff.bitcnt != 3'h0 && !s_ff.drop) begin
            nxt_s.fifo_wr = 1'b1;
            nxt_s.fifo_wdata = s_ff.sh;
          end
          nxt_s.lastbits = s_ff.bitcnt;
          nxt_s.offset = 3'h0;
          err_set[`ERR_CRC_BIT] = rx_dec_in.crc_bad ||
                                  rx_dec_in.crc_short;
          irq_set[`IRQ_RX_BIT] = 1'b1;
          nxt_s.st = rx_finish_transition;
        end else if (rx_dec_in.bit_valid && rx_dec_in.is_parity) begin
          // Parity after a partial first byte cannot be trusted
          if (!(s_ff.first_par && s_ff.offset != 3'h0) &&
              s_ff.ctrl[`CTRL_PAR_EN_BIT] &&
              (rx_dec_in.coll || rx_dec_in.bit_val !=
               (s_ff.ctrl[`CTRL_PAR_ODD_BIT] ? ~s_ff.par : s_ff.par))) begin
            err_set[`ERR_PARITY_BIT] = 1'b1;
          end
          nxt_s.first_par = 1'b0;
          nxt_s.par = 1'b0;
        end else if (rx_dec_in.bit_valid) begin
          nxt_s.dbits = s_ff.dbits + 8'h01;
          if (rx_dec_in.coll) begin
            err_set[`ERR_COLL_BIT] = 1'b1;
            if (!s_ff.coll_seen) begin
              nxt_s.collision_position = s_ff.dbits + 8'h01;
              nxt_s.coll_seen = 1'b1;
            end
          end
          nxt_s.sh[s_ff.bitcnt] = rx_dec_in.bit_val;
          nxt_s.par = s_ff.par ^ rx_dec_in.bit_val;
          nxt_s.bitcnt = s_ff.bitcnt + 3'h1;
          if (s_ff.bitcnt == 3'h7) begin
            nxt_s.fifo_wr = !s_ff.drop &&
              !(s_ff.first_byte && s_ff.offset == 3'h7);
            nxt_s.fifo_wdata = {rx_dec_in.bit_val, s_ff.sh[6:0]};
            nxt_s.sh = 8'h00;
            nxt_s.first_byte = 1'b0;
          end
        end
      end

      rx_finish_transition: begin
        // Code 100 again on the way out
        nxt_s.st = cmd_idle;
        nxt_s.cmd = `CMD_IDLE;
      end

      nv_addr_lo: begin
        if (s_ff.rd_pend) begin
          nxt_s.addr[7:0] = rbyte;
          nxt_s.st = nv_addr_hi;
        end
      end
      nv_addr_hi: begin
        if (s_ff.rd_pend) begin
          // Upper bits drop, so addresses wrap
          nxt_s.addr[8] = rbyte[0];
          nxt_s.st = nv_data;
        end
      end
      nv_data: begin
        if (s_ff.rd_pend) begin
          if (s_ff.addr < `NVM_PROT_END) begin
            // Byte dropped, address still moves
            err_set[`ERR_ACCESS_BIT] = 1'b1;
          end else begin
            nxt_s.buf_data[s_ff.addr[3:0]] = rbyte;
            nxt_s.mask[s_ff.addr[3:0]] = 1'b1;
            nxt_s.block = s_ff.addr[8:4];
            start_prog = (s_ff.addr[3:0] == 4'hF);
          end
          nxt_s.addr = s_ff.addr + 9'h001;
        end else if (fifo_empty_in && !s_ff.fifo_rd && !s_ff.prog &&
                     !s_ff.prog_start && s_ff.mask != 16'h0000) begin
          start_prog = 1'b1;
        end
      end
      default: begin
        nxt_s.st = cmd_idle;
      end
    endcase

    // No FIFO reads while this runs
    if (start_prog) begin
      nxt_s.prog = 1'b1;
      nxt_s.prog_start = 1'b1;
      nxt_s.prog_cnt = PROG_CYCLES - 20'h00001;
    end

    // Done only when nothing is pending anywhere in the write path
    nxt_s.done = (s_ff.st == nv_data) && !s_ff.rd_pend && !s_ff.fifo_rd &&
                 fifo_empty_in && !s_ff.prog && !s_ff.prog_start &&
                 !start_prog && s_ff.mask == 16'h0000 &&
                 nxt_s.st == nv_data;
    // Same edge as done, seen together
    irq_set[`IRQ_TX_BIT] = nxt_s.done && !s_ff.done;

    // Register writes
    if (wr_acc) begin
      case (apb_in.paddr)
        `OFS_CMD: begin
          // A running write cannot be cut off before it is done
          if (!(in_write(s_ff.st) && !s_ff.done)) begin
            case (apb_in.pwdata[5:0])
              `CMD_TRANSCEIVE: begin
                nxt_s.st = send_payload;
                nxt_s.cmd = `CMD_TRANSCEIVE;
                nxt_s.tx_start = 1'b1;
                nxt_s.lastbits = 3'h0;
                nxt_s.collision_position = 8'h00;
                err_clr = 5'h1F;
              end
              `CMD_NVM_WRITE: begin
                nxt_s.st = nv_addr_lo;
                nxt_s.cmd = `CMD_NVM_WRITE;
                nxt_s.done = 1'b0;
                nxt_s.mask = 16'h0000;
                err_clr = 5'h1F;
              end
              `CMD_IDLE: begin
                nxt_s.st = cmd_idle;
                nxt_s.cmd = `CMD_IDLE;
                nxt_s.done = 1'b0;
              end
              default: begin
              end
            endcase
          end
        end
        `OFS_FRAME: nxt_s.offset = apb_in.pwdata[6:4];
        `OFS_CTRL: nxt_s.ctrl = apb_in.pwdata[1:0];
        `OFS_RECEIVE_WAIT_DELAY: nxt_s.receive_wait_delay = apb_in.pwdata[7:0];
        `OFS_PHASE: nxt_s.phase = apb_in.pwdata[7:0];
        `OFS_IRQ: irq_clr = apb_in.pwdata[1:0];
        default: begin
        end
      endcase
    end

    // Hardware set wins over a clear in the same cycle
    nxt_s.errs = (s_ff.errs & ~err_clr) | err_set;
    nxt_s.irq = (s_ff.irq & ~irq_clr) | irq_set;
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // Only settings leave reset nonzero
      s_ff <= '0;
      s_ff.st <= cmd_idle;
      s_ff.ctrl <= `CTRL_RST;
      s_ff.receive_wait_delay <= `RECEIVE_WAIT_DELAY_RST;
      s_ff.phase <= `PHASE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign apb_out.prdata = s_ff.prdata;
  // Zero wait states
  assign apb_out.pready = apb_in.psel && apb_in.penable;
  assign apb_out.pslverr = apb_in.psel && apb_in.penable &&
                           !is_mapped(apb_in.paddr);
  assign fifo_rd_out = s_ff.fifo_rd;
  assign fifo_wr_out = s_ff.fifo_wr;
  assign fifo_wdata_out = s_ff.fifo_wdata;
  assign tx_start_out = s_ff.tx_start;
  assign tx_rx_clock_phase_out = s_ff.phase;
  // Receiver on only when armed or busy
  assign rx_enable_out = (s_ff.st == rx_armed) || (s_ff.st == receiving);
  assign nvm_out.start = s_ff.prog_start;
  assign nvm_out.block = s_ff.block;
  assign nvm_out.mask = s_ff.mask;
  assign nvm_out.data = s_ff.buf_data;

endmodule

// ---- rf_nvm_defines.svh ----
`ifndef RF_NVM_DEFINES_SVH
`define RF_NVM_DEFINES_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CMD 8'h00
`define OFS_STATUS 8'h04
`define OFS_ERR 8'h08
`define OFS_FRAME 8'h0C
`define OFS_CTRL 8'h10
`define OFS_RECEIVE_WAIT_DELAY 8'h14
`define OFS_PHASE 8'h18
`define OFS_COLLISION_POSITION 8'h1C
`define OFS_IRQ 8'h20

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define CMD_IDLE 6'h00
`define CMD_NVM_WRITE 6'h01
`define CMD_TRANSCEIVE 6'h1E

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define FRAME_OFFSET_LSB 4
`define CTRL_PAR_EN_BIT 0
`define CTRL_PAR_ODD_BIT 1
`define ERR_COLL_BIT 0
`define ERR_PARITY_BIT 1
`define ERR_FRAME_BIT 2
`define ERR_CRC_BIT 3
`define ERR_ACCESS_BIT 4
`define IRQ_TX_BIT 0
`define IRQ_RX_BIT 1

// ------------------------------------------------------------
// Link state codes
// ------------------------------------------------------------
`define LINK_IDLE 3'h0
`define LINK_TRANSITION 3'h4
`define LINK_RX_WAIT 3'h5
`define LINK_RX_ARMED 3'h6
`define LINK_RECEIVING 3'h7

// ------------------------------------------------------------
// Reset values, limits and timing
// ------------------------------------------------------------
`define CTRL_RST 2'h3
`define RECEIVE_WAIT_DELAY_RST 8'h06
`define PHASE_RST 8'h00
`define NVM_PROT_END 9'h010
`define CLK_PERIOD_NS 10
`define PROG_TIME_NS 5800000
`define PROG_CYCLES (`PROG_TIME_NS / `CLK_PERIOD_NS)

`endif

// ---- rf_nvm_pkg.sv ----
package rf_nvm_pkg;

  typedef enum logic [3:0] {
    cmd_idle = 4'h0,
    send_payload = 4'h1,
    rx_start_transition = 4'h2,
    rx_wait_phase = 4'h3,
    rx_armed = 4'h4,
    receiving = 4'h5,
    rx_finish_transition = 4'h6,
    nv_addr_lo = 4'h7,
    nv_addr_hi = 4'h8,
    nv_data = 4'h9
  } cmd_state_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic sof;
    logic bad_sof;
    logic bit_valid;
    logic bit_val;
    logic coll;
    logic is_parity;
    logic frame_end;
    logic crc_bad;
    logic crc_short;
  } rx_dec_type;

  typedef struct packed {
    logic start;
    logic [4:0] block;
    logic [15:0] mask;
    logic [15:0][7:0] data;
  } nvm_req_type;

  typedef struct packed {
    cmd_state_type st;
    logic [5:0] cmd;
    logic [2:0] offset;
    logic [1:0] ctrl;
    logic [7:0] receive_wait_delay;
    logic [7:0] phase;
    logic [7:0] wait_cnt;
    logic [7:0] sh;
    logic [2:0] bitcnt;
    logic first_byte;
    logic first_par;
    logic par;
    logic drop;
    logic [2:0] lastbits;
    logic [7:0] collision_position;
    logic coll_seen;
    logic [7:0] dbits;
    logic [4:0] errs;
    logic [1:0] irq;
    logic [8:0] addr;
    logic [4:0] block;
    logic [15:0][7:0] buf_data;
    logic [15:0] mask;
    logic [19:0] prog_cnt;
    logic prog;
    logic prog_start;
    logic done;
    logic rd_pend;
    logic fifo_rd;
    logic fifo_wr;
    logic [7:0] fifo_wdata;
    logic tx_start;
    logic [31:0] prdata;
  } state_type;

endpackage

// ---- rf_frame_nvm_sva.sv ----
`include "rf_nvm_defines.svh"
module rf_frame_nvm_sva (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Watched ports
  input wire rf_nvm_pkg::apb_req_type apb_in,
  input wire rf_nvm_pkg::apb_rsp_type apb_out,
  input wire logic fifo_rd_out,
  input wire logic fifo_wr_out,
  input wire logic tx_start_out,
  input wire logic [7:0] tx_rx_clock_phase_out,
  input wire rf_nvm_pkg::rx_dec_type rx_dec_in,
  input wire logic rx_enable_out,
  input wire rf_nvm_pkg::nvm_req_type nvm_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import rf_nvm_pkg::*;
  logic acc;
  assign acc = apb_in.psel && apb_in.penable && apb_in.pwrite;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_pready_zero_wait: assert property (apb_in.psel && apb_in.penable
    |-> apb_out.pready) else $error("pready late");
  a_unmapped_error: assert property (apb_in.psel && apb_in.penable &&
    apb_in.paddr > `OFS_IRQ |-> apb_out.pslverr) else $error("no pslverr");
  a_tx_start_cause: assert property (tx_start_out |->
    $past(acc && apb_in.paddr == `OFS_CMD &&
    apb_in.pwdata[5:0] == `CMD_TRANSCEIVE) || $past(acc &&
    apb_in.paddr == `OFS_CMD && apb_in.pwdata[5:0] == `CMD_TRANSCEIVE, 2))
    else $error("stray tx start");
  a_phase_follows: assert property (acc && apb_in.paddr == `OFS_PHASE
    |=> tx_rx_clock_phase_out == $past(apb_in.pwdata[7:0]))
    else $error("phase not applied");
  a_rx_stops_end: assert property (rx_enable_out &&
    rx_dec_in.frame_end |-> ##[1:3] !rx_enable_out)
    else $error("receiver left on");
  a_rx_write_window: assert property (fifo_wr_out |->
    $past(rx_enable_out) || $past(rx_enable_out, 2))
    else $error("fifo write outside receive");
  a_read_spacing: assert property (fifo_rd_out |=> !fifo_rd_out)
    else $error("fifo read too close");
  a_prog_quiet: assert property (nvm_out.start |=>
    (!fifo_rd_out && !nvm_out.start) [*8]) else $error("busy overlap");
  a_buffer_steady: assert property (nvm_out.start |=>
    ($stable(nvm_out.data) && $stable(nvm_out.mask) &&
    $stable(nvm_out.block)) [*8])
    else $error("buffer moved");
  a_block_zero_safe: assert property (nvm_out.start |->
    nvm_out.block != 5'h00 && nvm_out.mask != 16'h0000)
    else $error("bad programming cycle");
  c_tx: cover property (tx_start_out);
  c_prog: cover property (nvm_out.start);
  c_rx_byte: cover property (fifo_wr_out);
  c_frame_end: cover property (rx_enable_out && rx_dec_in.frame_end);
endmodule

bind rf_frame_nvm rf_frame_nvm_sva u_sva (.clk_in(clk_in),
  .nrst_in(nrst_in), .apb_in(apb_in), .apb_out(apb_out),
  .fifo_rd_out(fifo_rd_out), .fifo_wr_out(fifo_wr_out),
  .tx_start_out(tx_start_out),
  .tx_rx_clock_phase_out(tx_rx_clock_phase_out),
  .rx_dec_in(rx_dec_in), .rx_enable_out(rx_enable_out),
  .nvm_out(nvm_out));

// ---- card_model.sv ----
module card_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Device side
  input wire logic tx_start_in,
  input wire logic rx_enable_in,
  output logic [1:0] tx_phase_out,
  output logic tx_done_out,
  output logic bit_tick_out,
  output rf_nvm_pkg::rx_dec_type rx_dec_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import rf_nvm_pkg::*;
  logic [63:0] bits = '0;
  logic [63:0] par = '0;
  logic [63:0] col = '0;
  int nbits = 0;
  logic bad_sof = 1'b0;
  logic crc_bad = 1'b0;
  logic crc_short = 1'b0;
  logic [1:0] tick_cnt;
  rx_dec_type d;
  // Bit clock runs free; only the wait count depends on it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) tick_cnt <= 2'h0;
    else tick_cnt <= tick_cnt + 2'h1;
  end
  assign bit_tick_out = tick_cnt == 2'h3;
  // Idle data line shows the inverse so stale values never pass
  task put(input rx_dec_type v);
    logic b;
    b = ~v.bit_val;
    rx_dec_out <= v;
    @(posedge clk_in);
    v = '0;
    v.bit_val = b;
    rx_dec_out <= v;
    repeat (3) @(posedge clk_in);
  endtask
  initial begin
    tx_phase_out = 2'h0;
    tx_done_out = 1'b0;
    rx_dec_out = '0;
    forever begin
      @(posedge clk_in);
      if (tx_start_in === 1'b1) begin
        for (int p = 1; p < 4; p++) begin
          tx_phase_out <= 2'(p);
          repeat (20) @(posedge clk_in);
        end
        tx_phase_out <= 2'h0;
        tx_done_out <= 1'b1;
        @(posedge clk_in);
        tx_done_out <= 1'b0;
        while (rx_enable_in !== 1'b1) @(posedge clk_in);
        repeat (40) @(posedge clk_in);
        d = '0;
        d.sof = !bad_sof;
        d.bad_sof = bad_sof;
        put(d);
        for (int i = 0; i < nbits; i++) begin
          d = '0;
          d.bit_valid = 1'b1;
          d.bit_val = bits[i];
          d.is_parity = par[i];
          d.coll = col[i];
          put(d);
        end
        d = '0;
        d.frame_end = 1'b1;
        d.crc_bad = crc_bad;
        d.crc_short = crc_short;
        put(d);
      end
    end
  end
endmodule

// ---- test_rf_frame_and_nvm_write_cmds.sv ----
`include "rf_nvm_defines.svh"
module test_rf_frame_and_nvm_write_cmds;
  timeunit 1ns;
  timeprecision 1ps;
  import rf_nvm_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  apb_req_type req = '0;
  apb_rsp_type rsp;
  logic fifo_empty_in = 1'b1;
  logic [7:0] fifo_rdata_in = 8'h00;
  logic fifo_rd_out, fifo_wr_out, tx_start_out, tx_done_in, bit_tick_in;
  logic rx_enable_out, err_seen;
  logic [1:0] tx_phase_in;
  logic [7:0] fifo_wdata_out, phase_out, ph;
  rx_dec_type rx_dec;
  nvm_req_type nvm_out, me;
  logic [15:0] mw;
  logic [31:0] seed = 32'd1180;
  int n_errors = 0;
  int checks = 0;
  logic [7:0] fq[$];
  logic [15:0] exp_rx[$];
  nvm_req_type exp_nvm[$];
  always #5 clk_in = ~clk_in;
  rf_frame_nvm #(.PROG_CYCLES(20'd20)) u_dut (.clk_in(clk_in),
    .nrst_in(nrst_in), .apb_in(req), .apb_out(rsp),
    .fifo_empty_in(fifo_empty_in), .fifo_rdata_in(fifo_rdata_in),
    .fifo_rd_out(fifo_rd_out), .fifo_wr_out(fifo_wr_out),
    .fifo_wdata_out(fifo_wdata_out), .tx_start_out(tx_start_out),
    .tx_phase_in(tx_phase_in), .tx_done_in(tx_done_in),
    .tx_rx_clock_phase_out(phase_out), .bit_tick_in(bit_tick_in),
    .rx_dec_in(rx_dec), .rx_enable_out(rx_enable_out), .nvm_out(nvm_out));
  card_model u_card (.clk_in(clk_in), .nrst_in(nrst_in),
    .tx_start_in(tx_start_out), .rx_enable_in(rx_enable_out),
    .tx_phase_out(tx_phase_in), .tx_done_out(tx_done_in),
    .bit_tick_out(bit_tick_in), .rx_dec_out(rx_dec));
  // --------
  // Tasks
  // --------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d,
           output logic [31:0] r);
    @(posedge clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_in);
    req.penable <= 1'b1;
    @(posedge clk_in);
    while (rsp.pready !== 1'b1) @(posedge clk_in);
    r = rsp.prdata;
    err_seen = rsp.pslverr;
    req <= '0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(a, 1'b1, d, r);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    apb(a, 1'b0, 32'h0, r);
    chk(r & m, e);
  endtask
  // Bounded polling: a stuck flag shows as a mismatch, not a hang
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    r = ~e;
    for (int k = 0; k < 300 && (r & m) !== e; k++) apb(a, 1'b0, 32'h0, r);
    chk(r & m, e);
  endtask
  task rx_run(input int off, input logic pe, input int kind,
              input logic [4:0] ee);
    int nd, pos, j;
    logic [7:0] cur, cm;
    logic x, first, b;
    int codes[6] = '{1, 2, 3, 5, 6, 7};
    nd = 9 + int'(rnd() % 20);
    pos = off;
    {cur, cm, x, first, j} = {16'h0, 2'h3, 32'h0};
    u_card.par = '0;
    u_card.col = '0;
    for (int k = 0; k < nd; k++) begin
      b = 1'(rnd());
      if (kind == 4 && k == 2) {b, u_card.col[j]} = 2'h3;
      u_card.bits[j] = b;
      j++;
      {cur[pos], cm[pos]} = {b, 1'b1};
      x ^= b;
      pos++;
      if (pos == 8) begin
        if (!(off == 7 && first)) exp_rx.push_back({cm, cur});
        if (pe) begin
          u_card.bits[j] = x ^ (kind == 3 && first);
          u_card.par[j] = 1'b1;
          j++;
        end
        {pos, cur, cm, x, first} = {48'h0, 2'h2};
      end
    end
    if (pos > 0) exp_rx.push_back({cm, cur});
    if (kind == 1) exp_rx.delete();
    u_card.nbits = j;
    u_card.bad_sof = kind == 1;
    u_card.crc_bad = kind == 2;
    u_card.crc_short = kind == 5;
    wr(`OFS_CTRL, {30'h0, 1'b1, pe});
    wr(`OFS_FRAME, 32'(off) << 4);
    wr(`OFS_IRQ, 32'h3);
    wr(`OFS_CMD, 32'(`CMD_TRANSCEIVE));
    foreach (codes[i]) poll(`OFS_STATUS, 32'h70, 32'(codes[i]) << 4);
    poll(`OFS_CMD, 32'h3F, 32'h0);
    rdc(`OFS_STATUS, 32'h78, {28'h0, ee != 5'h0, 3'h0});
    rdc(`OFS_ERR, 32'h1F, 32'(ee));
    rdc(`OFS_IRQ, 32'h2, 32'h2);
    if (kind != 1) rdc(`OFS_FRAME, 32'h77, 32'(pos));
    if (kind == 4) rdc(`OFS_COLLISION_POSITION, 32'hFF, 32'h3);
    chk(32'(exp_rx.size()), 32'h0);
    $display("receive test offset=%0d kind=%0d ended", off, kind);
  endtask
  task mem_run(input logic [7:0] lo, input logic [7:0] hi, input int n,
               input int more, input logic [4:0] ee);
    logic [8:0] a;
    nvm_req_type e;
    logic [7:0] d;
    logic [7:0] dq[$];
    a = {hi[0], lo};
    e = '0;
    fq.push_back(lo);
    fq.push_back(hi);
    for (int k = 0; k < n + more; k++) begin
      d = 8'(rnd());
      if (a >= `NVM_PROT_END) begin
        {e.start, e.block, e.mask[a[3:0]], e.data[a[3:0]]} =
          {1'b1, a[8:4], 1'b1, d};
      end
      if (e.start && (a[3:0] == 4'hF || k == n - 1 || k == n + more - 1)) begin
        exp_nvm.push_back(e);
        e = '0;
      end
      a++;
      if (k < n) fq.push_back(d);
      else dq.push_back(d);
    end
    repeat (2) @(posedge clk_in);
    wr(`OFS_IRQ, 32'h3);
    wr(`OFS_CMD, 32'(`CMD_NVM_WRITE));
    wr(`OFS_CMD, 32'(`CMD_IDLE));
    rdc(`OFS_CMD, 32'h3F, 32'(`CMD_NVM_WRITE));
    poll(`OFS_STATUS, 32'h4, 32'h4);
    rdc(`OFS_IRQ, 32'h1, 32'h1);
    if (more > 0) begin
      wr(`OFS_IRQ, 32'h3);
      foreach (dq[i]) fq.push_back(dq[i]);
      repeat (10) @(posedge clk_in);
      poll(`OFS_STATUS, 32'h4, 32'h4);
      rdc(`OFS_IRQ, 32'h1, 32'h1);
    end
    rdc(`OFS_ERR, 32'h1F, 32'(ee));
    wr(`OFS_CMD, 32'(`CMD_IDLE));
    rdc(`OFS_CMD, 32'h3F, 32'h0);
    chk(32'(exp_nvm.size()), 32'h0);
    $display("memory write test at %h ended", {hi, lo});
  endtask
  task complete_run;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // --------
  // FIFO and result monitors
  // --------
  always @(posedge clk_in) begin
    if (fifo_rd_out && fq.size() > 0) fifo_rdata_in <= fq.pop_front();
    fifo_empty_in <= fq.size() == 0;
    if (fifo_wr_out) begin
      mw = exp_rx.size() > 0 ? exp_rx.pop_front() : 16'h00FF;
      chk(32'(fifo_wdata_out & mw[15:8]), 32'(mw[7:0]));
    end
    if (nvm_out.start) begin
      me = exp_nvm.size() > 0 ? exp_nvm.pop_front() : '0;
      chk({nvm_out.block, nvm_out.mask}, {me.block, me.mask});
      for (int k = 0; k < 16; k++)
        if (me.mask[k]) chk(32'(nvm_out.data[k]), 32'(me.data[k]));
    end
  end
  // --------
  // Main sequence
  // --------
  initial begin
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    rdc(`OFS_CTRL, 32'hFFFFFFFF, 32'h3);
    rdc(`OFS_RECEIVE_WAIT_DELAY, 32'hFFFFFFFF, 32'h6);
    rdc(`OFS_CMD, 32'hFFFFFFFF, 32'h0);
    rdc(8'h24, 32'hFFFFFFFF, 32'h0);
    chk(32'(err_seen), 32'h1);
    ph = 8'(rnd());
    wr(`OFS_PHASE, {24'h0, ph});
    @(posedge clk_in);
    chk(32'(phase_out), 32'(ph));
    $display("register test ended");
    rx_run(0, 1'b0, 0, 5'h00);
    rx_run(3, 1'b0, 0, 5'h00);
    rx_run(7, 1'b0, 0, 5'h00);
    rx_run(0, 1'b0, 1, 5'h04);
    rx_run(0, 1'b0, 2, 5'h08);
    rx_run(0, 1'b0, 5, 5'h08);
    rx_run(0, 1'b1, 3, 5'h02);
    rx_run(3, 1'b1, 3, 5'h00);
    rx_run(0, 1'b0, 4, 5'h01);
    mem_run(8'h6C, 8'h01, 5, 2, 5'h00);
    mem_run(8'h0E, 8'hFE, 3, 0, 5'h10);
    complete_run;
  end
  initial begin
    #1000000;
    n_errors++;
    complete_run;
  end
endmodule
